//--- hdl/fwsr_cyc_if.sv
// One flash bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface fwsr_cyc_if;
    logic                        req;
    logic                        write;
    logic [fwsr_pkg::ADDR_W-1:0] addr;
    logic [fwsr_pkg::DATA_W-1:0] wdata;
    logic                        ack;
    logic [fwsr_pkg::DATA_W-1:0] rdata;
    modport seq    (output req, write, addr, wdata, input ack, rdata);
    modport engine (input req, write, addr, wdata, output ack, rdata);
endinterface : fwsr_cyc_if
`default_nettype wire

//--- hdl/fwsr_pin_cycle.sv
// Flash pin engine: one timed read or write cycle per request
`timescale 1ns/1ps
`default_nettype none
module fwsr_pin_cycle #(
    parameter int PULSE_CYC   = fwsr_pkg::PULSE_CYC,
    parameter int RECOVER_CYC = fwsr_pkg::RECOVER_CYC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Request
    fwsr_cyc_if.engine                       cyc,
    input  wire logic [fwsr_pkg::DATA_W-1:0] dq_sync,
    // Flash pins
    output logic                             ce_n,
    output logic                             oe_n,
    output logic                             we_n,
    output logic      [fwsr_pkg::ADDR_W-1:0] addr,
    output logic      [fwsr_pkg::DATA_W-1:0] dq_o,
    output logic                             dq_oe
);
    typedef enum logic [1:0] {
        PC_IDLE = 2'b00,
        PC_ACT  = 2'b01,
        PC_REC  = 2'b10
    } fwsr_pc_t;

    fwsr_pc_t   state;
    logic [7:0] cnt;

    if (PULSE_CYC < 1 || RECOVER_CYC < 1 || PULSE_CYC > 200 || RECOVER_CYC > 200) begin : g_chk
        $error("fwsr_pin_cycle: cycle counts out of range");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= PC_IDLE;
            cnt       <= 8'h00;
            ce_n      <= 1'b1;
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            addr      <= '0;
            dq_o      <= '0;
            dq_oe     <= 1'b0;
            cyc.ack   <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            cyc.ack <= 1'b0;
            unique case (state)
                PC_IDLE: if (cyc.req && !cyc.ack) begin
                    addr  <= cyc.addr;
                    ce_n  <= 1'b0;
                    state <= PC_ACT;
                    if (cyc.write) begin
                        we_n  <= 1'b0;
                        dq_oe <= 1'b1;
                        dq_o  <= cyc.wdata;
                        cnt   <= 8'(PULSE_CYC - 1);
                    end else begin
                        // Each read is its own output-enable pulse
                        oe_n <= 1'b0;
                        cnt  <= 8'(PULSE_CYC + fwsr_pkg::SYNC_STAGES - 1);
                    end
                end
                PC_ACT: if (cnt == 8'h00) begin
                    if (!oe_n) begin
                        cyc.rdata <= dq_sync;
                    end
                    ce_n  <= 1'b1;
                    oe_n  <= 1'b1;
                    we_n  <= 1'b1;
                    cnt   <= 8'(RECOVER_CYC - 1);
                    state <= PC_REC;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                PC_REC: if (cnt == 8'h00) begin
                    dq_oe   <= 1'b0;
                    cyc.ack <= 1'b1;
                    state   <= PC_IDLE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                default: state <= PC_IDLE;
            endcase
        end
    end
endmodule : fwsr_pin_cycle
`default_nettype wire

//--- hdl/fwsr_pkg.sv
// Constants and types shared by the flash status host controller
package fwsr_pkg;
    // Clock and flash bus timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS      = 70;
    localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS    = 30;
    localparam int RECOVER_CYC   = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;
    localparam int ADDR_W        = 22;
    localparam int DATA_W        = 8;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    // Status byte bit positions on the flash data bus
    localparam int BIT_POLL    = 7;
    localparam int BIT_TOGGLE1 = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_WINDOW  = 3;
    localparam int BIT_TOGGLE2 = 2;
    // Sticky event bits in the status register
    localparam int EV_DONE   = 0;
    localparam int EV_FAIL   = 1;
    localparam int EV_WINDOW = 2;
    localparam int EV_REJECT = 3;
    localparam int EV_SUSP   = 4;
    localparam int EV_BLOCK  = 5;
    localparam int EV_W      = 6;
    // Flash unlock cycles and command bytes, plain defaults
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002AA;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 8'h55;
    localparam logic [DATA_W-1:0] FC_PROG   = 8'hA0;
    localparam logic [DATA_W-1:0] FC_SETUP  = 8'h80;
    localparam logic [DATA_W-1:0] FC_SECTOR = 8'h30;
    localparam logic [DATA_W-1:0] FC_CHIP   = 8'h10;
    localparam logic [DATA_W-1:0] FC_RESET  = 8'hF0;
    localparam logic [DATA_W-1:0] FC_SUSP   = 8'hB0;
    localparam logic [DATA_W-1:0] FC_RESUME = 8'h30;

    typedef enum logic [3:0] {
        CMD_READ   = 4'h0,
        CMD_PROG   = 4'h1,
        CMD_SECT   = 4'h2,
        CMD_ADD    = 4'h3,
        CMD_CHIP   = 4'h4,
        CMD_RESET  = 4'h5,
        CMD_SUSP   = 4'h6,
        CMD_RESUME = 4'h7,
        CMD_POLL   = 4'h8
    } fwsr_cmd_t;

    typedef struct packed {
        logic              last;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fwsr_wr_t;
endpackage : fwsr_pkg

//--- hdl/fwsr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fwsr_sync #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta[i] <= 1'b0;
                q[i]    <= 1'b0;
            end else begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end
endmodule : fwsr_sync
`default_nettype wire

//--- hdl/fwsr_top.sv
// Flash status host controller: APB registers, command sequencer, status polling
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fwsr_top (
    // APB clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic [7:0]                  paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Flash control pins
    output logic                             flash_ce_n,
    output logic                             flash_oe_n,
    output logic                             flash_we_n,
    output logic      [fwsr_pkg::ADDR_W-1:0] flash_addr,
    // Flash data pins
    output logic      [fwsr_pkg::DATA_W-1:0] flash_dq_o,
    output logic                             flash_dq_oe,
    input  wire logic [fwsr_pkg::DATA_W-1:0] flash_dq_i,
    // Flash ready/busy, open drain, high when ready
    input  wire logic                        ready_busy_out
);
    typedef enum logic [3:0] {
        S_IDLE     = 4'h0,
        S_READ     = 4'h1,
        S_PRECHK   = 4'h2,
        S_WIN_PRE  = 4'h3,
        S_WRITE    = 4'h4,
        S_POLL_A   = 4'h5,
        S_POLL_B   = 4'h6,
        S_WIN_POST = 4'h7,
        S_RESET_WR = 4'h8
    } fwsr_state_t;

    fwsr_cyc_if cyc ();

    fwsr_state_t                 state;
    fwsr_pkg::fwsr_cmd_t         cmd;
    fwsr_pkg::fwsr_wr_t          wr_step;
    logic [2:0]                  step;
    logic [fwsr_pkg::DATA_W-1:0] first;
    logic                        recheck;
    logic [fwsr_pkg::EV_W-1:0]   evt;
    logic [fwsr_pkg::EV_W-1:0]   sticky;
    logic [fwsr_pkg::ADDR_W-1:0] target;
    logic [fwsr_pkg::DATA_W-1:0] wdata;
    logic [fwsr_pkg::DATA_W-1:0] last;
    logic [fwsr_pkg::DATA_W-1:0] dq_s;
    logic                        rdy_s;
    logic                        apb_acc;
    logic                        apb_wr;
    logic                        start;
    logic [fwsr_pkg::DATA_W-1:0] d;

    // Pin inputs through two flops before use
    fwsr_sync #(
        .WIDTH (fwsr_pkg::DATA_W + 1)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({ready_busy_out, flash_dq_i}),
        .q     ({rdy_s, dq_s})
    );

    fwsr_pin_cycle u_pins (
        .clk     (pclk),
        .rst_n   (presetn),
        .cyc     (cyc),
        .dq_sync (dq_s),
        .ce_n    (flash_ce_n),
        .oe_n    (flash_oe_n),
        .we_n    (flash_we_n),
        .addr    (flash_addr),
        .dq_o    (flash_dq_o),
        .dq_oe   (flash_dq_oe)
    );

    // Write cycle table per command
    function automatic fwsr_pkg::fwsr_wr_t seq_step(
        input fwsr_pkg::fwsr_cmd_t         c,
        input logic [2:0]                  i,
        input logic [fwsr_pkg::ADDR_W-1:0] a,
        input logic [fwsr_pkg::DATA_W-1:0] w
    );
        fwsr_pkg::fwsr_wr_t r;
        r = '{last: 1'b1, addr: a, data: fwsr_pkg::FC_RESET};
        if (c == fwsr_pkg::CMD_PROG || c == fwsr_pkg::CMD_SECT || c == fwsr_pkg::CMD_CHIP) begin
            unique case (i)
                3'h0: r = '{1'b0, fwsr_pkg::UNLOCK_A1, fwsr_pkg::UNLOCK_D1};
                3'h1: r = '{1'b0, fwsr_pkg::UNLOCK_A2, fwsr_pkg::UNLOCK_D2};
                3'h2: r = (c == fwsr_pkg::CMD_PROG) ?
                          fwsr_pkg::fwsr_wr_t'{1'b0, fwsr_pkg::UNLOCK_A1, fwsr_pkg::FC_PROG} :
                          fwsr_pkg::fwsr_wr_t'{1'b0, fwsr_pkg::UNLOCK_A1, fwsr_pkg::FC_SETUP};
                3'h3: r = (c == fwsr_pkg::CMD_PROG) ? fwsr_pkg::fwsr_wr_t'{1'b1, a, w} :
                          fwsr_pkg::fwsr_wr_t'{1'b0, fwsr_pkg::UNLOCK_A1, fwsr_pkg::UNLOCK_D1};
                3'h4: r = '{1'b0, fwsr_pkg::UNLOCK_A2, fwsr_pkg::UNLOCK_D2};
                default: r = (c == fwsr_pkg::CMD_CHIP) ?
                             fwsr_pkg::fwsr_wr_t'{1'b1, fwsr_pkg::UNLOCK_A1, fwsr_pkg::FC_CHIP} :
                             fwsr_pkg::fwsr_wr_t'{1'b1, a, fwsr_pkg::FC_SECTOR};
            endcase
        end else if (c == fwsr_pkg::CMD_ADD) begin
            r = '{1'b1, a, fwsr_pkg::FC_SECTOR};
        end else if (c == fwsr_pkg::CMD_SUSP) begin
            r = '{1'b1, a, fwsr_pkg::FC_SUSP};
        end else if (c == fwsr_pkg::CMD_RESUME) begin
            r = '{1'b1, a, fwsr_pkg::FC_RESUME};
        end
        return r;
    endfunction : seq_step

    function automatic logic mapped(input logic [7:0] a);
        return a == fwsr_pkg::REG_CTRL || a == fwsr_pkg::REG_ADDR || a == fwsr_pkg::REG_WDATA ||
               a == fwsr_pkg::REG_STATUS || a == fwsr_pkg::REG_RDATA;
    endfunction : mapped

    // APB slave: one wait state, effect at the completing edge
    assign apb_acc = psel & penable & pready;
    assign apb_wr  = apb_acc & pwrite;
    assign start   = apb_wr && paddr == fwsr_pkg::REG_CTRL && state == S_IDLE &&
                     pwdata[3:0] <= fwsr_pkg::CMD_POLL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped(paddr);
            prdata  <= 32'h00000000;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    fwsr_pkg::REG_CTRL:   prdata <= {28'h0000000, cmd};
                    fwsr_pkg::REG_ADDR:   prdata <= {10'h000, target};
                    fwsr_pkg::REG_WDATA:  prdata <= {24'h000000, wdata};
                    fwsr_pkg::REG_STATUS: prdata <= {16'h0000, last, rdy_s, sticky,
                                                     state != S_IDLE};
                    fwsr_pkg::REG_RDATA:  prdata <= {24'h000000, last};
                    default:              prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Software operands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target <= '0;
            wdata  <= '0;
        end else if (apb_wr && state == S_IDLE) begin
            if (paddr == fwsr_pkg::REG_ADDR) begin
                target <= pwdata[fwsr_pkg::ADDR_W-1:0];
            end
            if (paddr == fwsr_pkg::REG_WDATA) begin
                wdata <= pwdata[fwsr_pkg::DATA_W-1:0];
            end
        end
    end

    // Sticky events, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky <= '0;
        end else if (apb_wr && paddr == fwsr_pkg::REG_STATUS) begin
            sticky <= (sticky & ~pwdata[fwsr_pkg::EV_W:1]) | evt;
        end else begin
            sticky <= sticky | evt;
        end
    end

    // Last byte read from the flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= '0;
        end else if (cyc.ack && !cyc.write) begin
            last <= cyc.rdata;
        end
    end

    // Cycle request contents held stable while req is high
    always_comb begin
        wr_step   = seq_step(cmd, step, target, wdata);
        cyc.write = (state == S_WRITE) || (state == S_RESET_WR);
        cyc.addr  = (state == S_WRITE) ? wr_step.addr : target;
        cyc.wdata = (state == S_WRITE) ? wr_step.data : fwsr_pkg::FC_RESET;
    end

    assign d = cyc.rdata;

    // Command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= S_IDLE;
            cmd     <= fwsr_pkg::CMD_READ;
            step    <= 3'h0;
            first   <= '0;
            recheck <= 1'b0;
            evt     <= '0;
            cyc.req <= 1'b0;
        end else begin
            evt <= '0;
            if (cyc.ack) begin
                cyc.req <= 1'b0;
            end else if (state != S_IDLE && !cyc.req) begin
                cyc.req <= 1'b1;
            end
            unique case (state)
                S_IDLE: if (start) begin
                    cmd     <= fwsr_pkg::fwsr_cmd_t'(pwdata[3:0]);
                    step    <= 3'h0;
                    recheck <= 1'b0;
                    unique case (pwdata[3:0])
                        fwsr_pkg::CMD_READ: state <= S_READ;
                        fwsr_pkg::CMD_PROG: state <= S_PRECHK;
                        fwsr_pkg::CMD_ADD:  state <= S_WIN_PRE;
                        fwsr_pkg::CMD_POLL: state <= S_POLL_A;
                        default:            state <= S_WRITE;
                    endcase
                end
                S_READ: if (cyc.ack) begin
                    evt[fwsr_pkg::EV_DONE] <= 1'b1;
                    state                  <= S_IDLE;
                end
                S_PRECHK: if (cyc.ack) begin
                    // A bit raised from 0 to 1 would only end in timeout
                    if (|(wdata & ~d)) begin
                        evt[fwsr_pkg::EV_BLOCK] <= 1'b1;
                        evt[fwsr_pkg::EV_DONE]  <= 1'b1;
                        state                   <= S_IDLE;
                    end else begin
                        state <= S_WRITE;
                    end
                end
                S_WIN_PRE: if (cyc.ack) begin
                    // Window closed: the add would be ignored
                    if (d[fwsr_pkg::BIT_WINDOW]) begin
                        evt[fwsr_pkg::EV_WINDOW] <= 1'b1;
                        evt[fwsr_pkg::EV_REJECT] <= 1'b1;
                        evt[fwsr_pkg::EV_DONE]   <= 1'b1;
                        state                    <= S_IDLE;
                    end else begin
                        state <= S_WRITE;
                    end
                end
                S_WRITE: if (cyc.ack) begin
                    if (!wr_step.last) begin
                        step <= step + 3'h1;
                    end else begin
                        step <= 3'h0;
                        unique case (cmd)
                            fwsr_pkg::CMD_ADD: state <= S_WIN_POST;
                            fwsr_pkg::CMD_RESET: begin
                                evt[fwsr_pkg::EV_DONE] <= 1'b1;
                                state                  <= S_IDLE;
                            end
                            default: state <= S_POLL_A;
                        endcase
                    end
                end
                S_POLL_A: if (cyc.ack) begin
                    first <= d;
                    state <= S_POLL_B;
                end
                S_POLL_B: if (cyc.ack) begin
                    if (d[fwsr_pkg::BIT_TOGGLE1] == first[fwsr_pkg::BIT_TOGGLE1]) begin
                        // Steady toggle one with toggling two: suspended sector
                        if (d[fwsr_pkg::BIT_TOGGLE2] != first[fwsr_pkg::BIT_TOGGLE2]) begin
                            evt[fwsr_pkg::EV_SUSP] <= 1'b1;
                        end
                        if (cmd == fwsr_pkg::CMD_SECT) begin
                            state <= S_WIN_POST;
                        end else begin
                            evt[fwsr_pkg::EV_DONE] <= 1'b1;
                            state                  <= S_IDLE;
                        end
                    end else if (cmd == fwsr_pkg::CMD_SECT) begin
                        state <= S_WIN_POST;
                    end else if (recheck) begin
                        evt[fwsr_pkg::EV_FAIL] <= 1'b1;
                        state                  <= S_RESET_WR;
                    end else begin
                        // Toggle may stop just as the timeout flag rises
                        recheck <= d[fwsr_pkg::BIT_TIMEOUT];
                        state   <= S_POLL_A;
                    end
                end
                S_WIN_POST: if (cyc.ack) begin
                    if (d[fwsr_pkg::BIT_WINDOW]) begin
                        evt[fwsr_pkg::EV_WINDOW] <= 1'b1;
                        evt[fwsr_pkg::EV_REJECT] <= (cmd == fwsr_pkg::CMD_ADD);
                    end
                    evt[fwsr_pkg::EV_DONE] <= 1'b1;
                    state                  <= S_IDLE;
                end
                S_RESET_WR: if (cyc.ack) begin
                    evt[fwsr_pkg::EV_DONE] <= 1'b1;
                    state                  <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule : fwsr_top
`default_nettype wire

//--- tb/fwsr_flash_model.sv
// Behavioural flash device answering the host pins
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model #(parameter int WIN_NS = 3000) (
    // Host pins
    input wire logic        ce_n, oe_n, we_n, stuck,
    input wire logic [21:0] a,
    input wire logic [7:0]  d,
    // Device outputs
    output logic [7:0]      q,
    output logic            rb,
    output int              resets
);
    logic [7:0]  mem [16];
    logic [7:0]  v = 8'h00, lv = 8'h00;
    logic [21:0] sa = 22'h0;
    logic [2:0]  m = 3'h0;
    logic        pp = 0, se = 0, t = 0, pd = 0;
    realtime     tw = 0;
    // Cycle ends when either strobe rises, chip select may rise first
    wire logic   wr_act = !ce_n && !we_n;
    wire logic   rd_act = !ce_n && !oe_n;
    initial begin
        resets = 0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // Closed erase window accepts only suspend
    always @(negedge wr_act) if (m != 3'h2 || $realtime - tw < WIN_NS || d == 8'hB0) begin
        if (pp) begin
            pp = 1'b0;
            pd = d[7];
            if (stuck) m = 3'h1;
            else mem[a[3:0]] &= d;
        end else case (d)
            8'hA0: pp = 1'b1;
            8'h80: se = 1'b1;
            8'hF0: begin m = 3'h0; se = 1'b0; resets++; end
            8'hB0: if (m == 3'h2) m = 3'h3;
            8'h10: if (se) begin m = 3'h4; se = 1'b0; tw = $realtime; end
            8'h30: if (m == 3'h3) m = 3'h2;
                else if (se || m == 3'h2) begin m = 3'h2; se = 1'b0; sa = a; tw = $realtime; end
            default: ;
        endcase
    end
    always #50 if ((m == 3'h2 || m == 3'h4) && $realtime - tw >= 2 * WIN_NS) m = 3'h0;
    always @(posedge rd_act) case (m)
        3'h1: v = {~pd, t, 1'b1, 5'h0};
        3'h2, 3'h4: v = {1'b0, t, 2'b0, m[2] || $realtime - tw >= WIN_NS,
            (m[2] || a[21:4] == sa[21:4]) & t, 2'b0};
        3'h3: v = (a[21:4] == sa[21:4]) ? {4'h8, 1'b0, t, 2'b0} : mem[a[3:0]];
        default: v = mem[a[3:0]];
    endcase
    always @(negedge rd_act) begin t = ~t; lv = v; end
    // Released bus shows the inverse of the last byte
    assign q = rd_act ? v : ~lv;
    assign rb = !(m == 3'h1 || m == 3'h2 || m == 3'h4);
endmodule : fwsr_flash_model
`default_nettype wire

//--- tb/fwsr_props.sv
// Port checker for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
module fwsr_props (
    // APB
    input wire logic        pclk, presetn, psel, penable, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    // Flash
    input wire logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe,
    input wire logic [21:0] flash_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("wait state");
    a_err_unmapped: assert property (pready |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})) else $error("pslverr");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata");
    a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*7] ##1 flash_we_n)
        else $error("we width");
    a_we_drives: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("we");
    a_oe_clean: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
        else $error("oe");
    a_addr_stable:
        assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
        else $error("addr moved");
endmodule : fwsr_props
bind fwsr_top fwsr_props i_fwsr_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_oe(flash_dq_oe), .flash_addr(flash_addr));
`default_nettype wire

//--- tb/fwsr_top_tb_top.sv
// Self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module fwsr_top_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stuck = 0;
    logic        pready, pslverr, ce_n, oe_n, we_n, rb, er;
    logic [7:0]  paddr = 8'h00, dq_o, dq_i;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [21:0] fa;
    int          num_errors = 0, n_compared = 0, cyc = 0, resets;
    fwsr_top i_fwsr_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(), .flash_dq_i(dq_i),
        .ready_busy_out(rb));
    fwsr_flash_model i_fwsr_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .stuck(stuck),
        .a(fa), .d(dq_o), .q(dq_i), .rb(rb), .resets(resets));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 20000) begin num_errors++; stop_test(); end
    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {r, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(r & m, e)
    endtask : rd
    // Clear events, load operands, start, wait for idle
    task automatic op(input logic [3:0] c, input logic [21:0] a, input logic [7:0] d);
        apb(1'b1, 8'h0C, 32'h7E);
        apb(1'b1, 8'h04, {10'h0, a});
        apb(1'b1, 8'h08, {24'h0, d});
        apb(1'b1, 8'h00, {28'h0, c});
        do apb(1'b0, 8'h0C, 32'h0); while (r[0] !== 1'b0);
    endtask : op
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h0C, 32'h8F, 32'h80);
        apb(1'b0, 8'h14, 32'h0);
        `CHK({er, r}, 33'h100000000)
        op(4'h1, 22'h3, 8'h5A);
        rd(8'h0C, 32'h46, 32'h02);
        op(4'h1, 22'h3, 8'hFF);
        rd(8'h0C, 32'h40, 32'h40);
        op(4'h0, 22'h3, 8'h00);
        rd(8'h10, 32'hFF, 32'h5A);
        stuck <= 1'b1;
        op(4'h1, 22'h4, 8'h00);
        rd(8'h0C, 32'h04, 32'h04);
        `CHK(resets, 1)
        stuck <= 1'b0;
        op(4'h2, 22'h10, 8'h00);
        rd(8'h0C, 32'h98, 32'h00);
        repeat (2) begin
            repeat (100) @(posedge pclk);
            op(4'h3, 22'h10, 8'h00);
            rd(8'h0C, 32'h18, 32'h00);
        end
        repeat (350) @(posedge pclk);
        op(4'h3, 22'h10, 8'h00);
        rd(8'h0C, 32'h18, 32'h18);
        op(4'h6, 22'h10, 8'h00);
        op(4'h8, 22'h10, 8'h00);
        rd(8'h0C, 32'h20, 32'h20);
        op(4'h7, 22'h10, 8'h00);
        repeat (700) @(posedge pclk);
        op(4'h5, 22'h10, 8'h00);
        op(4'h4, 22'h0, 8'h00);
        rd(8'h0C, 32'h0A, 32'h02);
        stop_test();
    end
endmodule : fwsr_top_tb_top
`default_nettype wire
